/* verilog/rmcg_params.svh */
`ifndef RMCG_PARAMS_SVH
`define RMCG_PARAMS_SVH

// system control base; the slave sees only the low offset bits
`define RMCG_SYSCTL_BASE 32'h400F_E000
// register byte offsets
`define RMCG_OFS_RUN_GATE 12'h104
`define RMCG_OFS_FAULT_STAT 12'h180
`define RMCG_OFS_FAULT_MASK 12'h184

// bit positions of the implemented gates in the run gate register
`define RMCG_POS_ASYNC0 0
`define RMCG_POS_ASYNC1 1
`define RMCG_POS_SYNC0 4
`define RMCG_POS_TWOW0 12
`define RMCG_POS_TWOW1 14
`define RMCG_POS_GPC0 16
`define RMCG_POS_GPC1 17
`define RMCG_POS_GPC2 18

// writable bits of the run gate register; all others read zero
`define RMCG_RUN_GATE_MASK 32'h0007_5013
// reset values
`define RMCG_RUN_GATE_RST 32'h0000_0000
`define RMCG_FAULT_STAT_RST 8'h00
`define RMCG_FAULT_MASK_RST 8'h00

// number of gated units
`define RMCG_UNIT_CNT 8

`endif

/* verilog/rmcg_pkg.sv */
package rmcg_pkg;

	// apb slave answer sequencing
	typedef enum logic [0:0] {
		RMCG_APB_IDLE = 1'b0,
		RMCG_APB_RESP = 1'b1
	} rmcg_apb_e;

	// unit index on the unit access port
	typedef logic [2:0] rmcg_unit_idx_t;

	// one bit per gated unit, index order of the unit access port
	typedef logic [7:0] rmcg_unit_vec_t;

endpackage

/* verilog/rmcg_unit_if.sv */
`timescale 1ns/1ps
`default_nettype none

// carries unit enables and unit access traffic to the fault watcher
interface rmcg_unit_if;
	rmcg_pkg::rmcg_unit_vec_t unit_en; // live clock enables
	logic req; // access aimed at a unit this cycle
	rmcg_pkg::rmcg_unit_idx_t idx; // which unit
	logic grant; // access completed normally
	logic fault; // access refused with bus fault

	modport top (output unit_en, output req, output idx,
		input grant, input fault);
	modport watch (input unit_en, input req, input idx,
		output grant, output fault);
endinterface

`default_nettype wire

/* verilog/rmcg_clk_gate.sv */
`timescale 1ns/1ps
`default_nettype none

// glitch-free gate: the enable is retimed on the falling edge so that
// it only changes while the clock is low, so no pulse is ever cut
module rmcg_clk_gate (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic en,
	output logic gclk
);
	logic en_lo_r; // enable held across the high phase

	// capture while clk is low-going; stays still during the high phase
	always_ff @(negedge clk or negedge rst_n)
	begin
		if (!rst_n)
			en_lo_r <= 1'b0;
		else
			en_lo_r <= en;
	end

	assign gclk = clk & en_lo_r;
endmodule

`default_nettype wire

/* verilog/rmcg_fault_watch.sv */
`timescale 1ns/1ps
`default_nettype none

// answers unit accesses: grant when the unit is clocked, fault if not
module rmcg_fault_watch (
	input wire logic clk,
	input wire logic rst_n,
	rmcg_unit_if.watch uif
);
	logic unit_live; // selected unit currently has its clock
	logic grant_r;
	logic fault_r;

	assign unit_live = uif.unit_en[uif.idx];

	// one-cycle answer to every request
	always_ff @(posedge clk or negedge rst_n)
	begin
		if (!rst_n)
		begin
			grant_r <= 1'b0;
			fault_r <= 1'b0;
		end
		else
		begin
			grant_r <= uif.req & unit_live;
			fault_r <= uif.req & ~unit_live;
		end
	end

	assign uif.grant = grant_r;
	assign uif.fault = fault_r;
endmodule

`default_nettype wire

/* verilog/rmcg_top.sv */
// Implementation choice: the APB slave port.
`timescale 1ns/1ps
`default_nettype none
`include "rmcg_params.svh"

module rmcg_top #(
	parameter int UNIT_CNT = `RMCG_UNIT_CNT
) (
	input wire logic pclk,
	input wire logic presetn,
	// apb slave
	input wire logic [11:0] paddr,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// low-power mode context
	input wire logic auto_clock_gating_select,
	input wire logic sleep_mode,
	input wire logic deep_sleep_mode,
	input wire logic [31:0] sleep_mode_unit_clock_gate_1,
	input wire logic [31:0] deep_sleep_unit_clock_gate_1,
	// access to gated units from the processor bus
	input wire logic unit_req,
	input wire logic [2:0] unit_req_idx,
	output logic unit_grant,
	output logic unit_fault,
	// per-unit clock enables and gated clocks
	output logic [UNIT_CNT-1:0] unit_clk_en,
	output logic [UNIT_CNT-1:0] unit_gclk,
	// level interrupt for unit bus faults
	output logic irq
);

	// the unit index port and status bits are fixed at eight units
	if (UNIT_CNT != 8)
	begin : g_cnt_check
		$error("rmcg_top: UNIT_CNT must be 8");
	end

	// gate bit position per unit index
	localparam int UNIT_POS [8] = '{`RMCG_POS_ASYNC0, `RMCG_POS_ASYNC1,
		`RMCG_POS_SYNC0, `RMCG_POS_TWOW0, `RMCG_POS_TWOW1,
		`RMCG_POS_GPC0, `RMCG_POS_GPC1, `RMCG_POS_GPC2};

	// ---------------------------------------------------------------
	// registers
	// ---------------------------------------------------------------
	logic [31:0] run_gate_r; // run-mode gate register
	logic [31:0] run_gate_nxt;
	rmcg_pkg::rmcg_unit_vec_t fault_stat_r; // sticky fault per unit
	rmcg_pkg::rmcg_unit_vec_t fault_stat_nxt;
	rmcg_pkg::rmcg_unit_vec_t fault_mask_r; // interrupt mask
	rmcg_pkg::rmcg_unit_vec_t fault_mask_nxt;
	rmcg_pkg::rmcg_apb_e apb_st_r; // slave answer state
	rmcg_pkg::rmcg_apb_e apb_st_nxt;
	logic [31:0] prdata_r;
	logic [31:0] prdata_nxt;
	logic pslverr_r;
	logic pslverr_nxt;
	logic pready_r;
	logic irq_r;
	logic irq_nxt;
	logic [UNIT_CNT-1:0] unit_clk_en_r; // live enables, registered
	logic [UNIT_CNT-1:0] unit_clk_en_nxt;
	logic rst_seen_r; // low in the first cycle after release

	// ---------------------------------------------------------------
	// apb decode
	// ---------------------------------------------------------------
	wire apb_setup; // setup phase seen this cycle
	wire apb_done; // access phase completes at this edge
	wire sel_gate; // run gate register addressed
	wire sel_stat; // fault status addressed
	wire sel_mask; // fault mask addressed
	wire sel_none; // unmapped offset
	wire wr_done; // write takes effect this edge
	wire rd_stat_done; // status read completes this edge
	wire [31:0] rd_mux; // read value chosen at setup

	assign apb_setup = psel & ~penable;
	assign apb_done = psel & penable & pready_r;
	assign sel_gate = (paddr == `RMCG_OFS_RUN_GATE);
	assign sel_stat = (paddr == `RMCG_OFS_FAULT_STAT);
	assign sel_mask = (paddr == `RMCG_OFS_FAULT_MASK);
	assign sel_none = ~(sel_gate | sel_stat | sel_mask);
	assign wr_done = apb_done & pwrite & ~pslverr_r;
	assign rd_stat_done = apb_done & ~pwrite & ~pslverr_r & sel_stat;

	// unused gate bits are masked off, so they always read zero
	assign rd_mux = sel_gate ? (run_gate_r & `RMCG_RUN_GATE_MASK) :
		sel_stat ? {24'h00_0000, fault_stat_r} :
		sel_mask ? {24'h00_0000, fault_mask_r} :
		32'h0000_0000;

	// answer state: setup edge loads the answer, access edge retires it
	always_comb
	begin
		apb_st_nxt = apb_st_r;
		prdata_nxt = prdata_r;
		pslverr_nxt = pslverr_r;
		case (apb_st_r)
			rmcg_pkg::RMCG_APB_IDLE:
			begin
				if (apb_setup)
				begin
					// read data captured here, so it cannot tear
					apb_st_nxt = rmcg_pkg::RMCG_APB_RESP;
					prdata_nxt = pwrite ? 32'h0000_0000 : rd_mux;
					pslverr_nxt = sel_none; // unmapped gets an error
				end
			end
			rmcg_pkg::RMCG_APB_RESP:
			begin
				if (apb_done)
				begin
					apb_st_nxt = rmcg_pkg::RMCG_APB_IDLE;
					pslverr_nxt = 1'b0;
				end
			end
			default:
				apb_st_nxt = rmcg_pkg::RMCG_APB_IDLE;
		endcase
	end

	// apb state and answer flops
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			apb_st_r <= rmcg_pkg::RMCG_APB_IDLE;
			prdata_r <= 32'h0000_0000;
			pslverr_r <= 1'b0;
			pready_r <= 1'b0;
		end
		else
		begin
			apb_st_r <= apb_st_nxt;
			prdata_r <= prdata_nxt;
			pslverr_r <= pslverr_nxt;
			// ready stands for exactly the one access cycle
			pready_r <= (apb_st_nxt == rmcg_pkg::RMCG_APB_RESP);
		end
	end

	// ---------------------------------------------------------------
	// gate and mask registers
	// ---------------------------------------------------------------
	// only implemented gate bits accept data; the rest stay zero
	assign run_gate_nxt = (wr_done & sel_gate) ?
		(pwdata & `RMCG_RUN_GATE_MASK) : run_gate_r;
	assign fault_mask_nxt = (wr_done & sel_mask) ?
		pwdata[7:0] : fault_mask_r;

	// reset leaves every unit unclocked until software enables it
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			run_gate_r <= `RMCG_RUN_GATE_RST;
			fault_mask_r <= `RMCG_FAULT_MASK_RST;
			rst_seen_r <= 1'b0;
		end
		else
		begin
			run_gate_r <= run_gate_nxt;
			fault_mask_r <= fault_mask_nxt;
			rst_seen_r <= 1'b1;
		end
	end

	// ---------------------------------------------------------------
	// mode selection of the governing gate word
	// ---------------------------------------------------------------
	wire use_sleep; // sleep register governs
	wire use_deep; // deep-sleep register governs
	wire [31:0] gov_gate; // gate word in force

	// run register rules unless auto gating is on and a low-power
	// mode is active; deep sleep outranks sleep
	assign use_deep = auto_clock_gating_select & deep_sleep_mode;
	assign use_sleep = auto_clock_gating_select & sleep_mode & ~use_deep;
	assign gov_gate = use_deep ? deep_sleep_unit_clock_gate_1 :
		use_sleep ? sleep_mode_unit_clock_gate_1 :
		run_gate_r;

	// pick each unit's bit out of the governing word
	for (genvar gi = 0; gi < 8; gi++)
	begin : g_unit
		assign unit_clk_en_nxt[gi] = gov_gate[UNIT_POS[gi]];

		// one glitch-free gate per unit, fed from the registered enable
		rmcg_clk_gate u_gate (
			.clk(pclk),
			.rst_n(presetn),
			.en(unit_clk_en_r[gi]),
			.gclk(unit_gclk[gi])
		);
	end

	// registered enables, also what the fault watcher judges by
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
			unit_clk_en_r <= '0;
		else
			unit_clk_en_r <= unit_clk_en_nxt;
	end

	// ---------------------------------------------------------------
	// unit access fault watch
	// ---------------------------------------------------------------
	rmcg_unit_if uif ();

	assign uif.unit_en = unit_clk_en_r;
	assign uif.req = unit_req;
	assign uif.idx = unit_req_idx;

	rmcg_fault_watch u_watch (
		.clk(pclk),
		.rst_n(presetn),
		.uif(uif)
	);

	// ---------------------------------------------------------------
	// sticky fault status and interrupt
	// ---------------------------------------------------------------
	rmcg_pkg::rmcg_unit_vec_t fault_evt; // fault raised this cycle
	rmcg_pkg::rmcg_unit_vec_t rd_clr; // bits the finishing read saw

	// watcher's fault is one cycle after the request; the index must
	// be held by the requester through the answer cycle
	assign fault_evt = uif.fault ? (8'h01 << unit_req_idx) : 8'h00;
	// only bits software actually saw are cleared; a fresh event wins
	assign rd_clr = rd_stat_done ? prdata_r[7:0] : 8'h00;
	assign fault_stat_nxt = (fault_stat_r & ~rd_clr) | fault_evt;
	assign irq_nxt = |(fault_stat_nxt & fault_mask_nxt);

	// status and irq flops; irq mirrors the next status to stay in step
	always_ff @(posedge pclk or negedge presetn)
	begin
		if (!presetn)
		begin
			fault_stat_r <= `RMCG_FAULT_STAT_RST;
			irq_r <= 1'b0;
		end
		else
		begin
			fault_stat_r <= fault_stat_nxt;
			irq_r <= irq_nxt;
		end
	end

	// ---------------------------------------------------------------
	// outputs
	// ---------------------------------------------------------------
	assign prdata = prdata_r;
	assign pready = pready_r;
	assign pslverr = pslverr_r;
	assign unit_grant = uif.grant;
	assign unit_fault = uif.fault;
	assign unit_clk_en = unit_clk_en_r;
	assign irq = irq_r;

	// ---------------------------------------------------------------
	// checks
	// ---------------------------------------------------------------
	AST_RESERVED_ZERO: assert property (
		@(posedge pclk) disable iff (!presetn)
		(run_gate_r & ~`RMCG_RUN_GATE_MASK) == 32'h0000_0000)
		else $error("reserved gate bits not zero");

	AST_READ_RESERVED: assert property (
		@(posedge pclk) disable iff (!presetn)
		(apb_setup && !pwrite && sel_gate && apb_st_r ==
		rmcg_pkg::RMCG_APB_IDLE) |=>
		pready_r && (prdata_r & ~`RMCG_RUN_GATE_MASK) == 32'h0000_0000)
		else $error("gate read shows reserved bits");

	AST_WRITE_TAKES: assert property (
		@(posedge pclk) disable iff (!presetn)
		(wr_done && sel_gate) |=>
		run_gate_r == ($past(pwdata) & `RMCG_RUN_GATE_MASK))
		else $error("gate write not stored");

	AST_DECODE: assert property (
		@(posedge pclk) disable iff (!presetn)
		(apb_setup && apb_st_r == rmcg_pkg::RMCG_APB_IDLE &&
		paddr != `RMCG_OFS_RUN_GATE && paddr != `RMCG_OFS_FAULT_STAT &&
		paddr != `RMCG_OFS_FAULT_MASK) |=> pready_r && pslverr_r)
		else $error("unmapped offset not refused");

	AST_RESET_CLEAR: assert property (
		@(posedge pclk) disable iff (!presetn)
		!rst_seen_r |-> run_gate_r == 32'h0000_0000 &&
		unit_clk_en_r == 8'h00)
		else $error("gates not clear after reset");

	AST_RUN_GOVERNS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(!auto_clock_gating_select && !(wr_done && sel_gate)) ##1
		!auto_clock_gating_select |=>
		unit_clk_en_r[5] == $past(run_gate_r[`RMCG_POS_GPC0], 2) &&
		unit_clk_en_r[3] == $past(run_gate_r[`RMCG_POS_TWOW0], 2))
		else $error("run gate not in force");

	AST_SLEEP_GOVERNS: assert property (
		@(posedge pclk) disable iff (!presetn)
		(auto_clock_gating_select && sleep_mode && !deep_sleep_mode) |=>
		unit_clk_en_r[2] == $past(sleep_mode_unit_clock_gate_1[4]))
		else $error("sleep gate not in force");

	AST_FAULT_OFF: assert property (
		@(posedge pclk) disable iff (!presetn)
		(unit_req && !unit_clk_en_r[unit_req_idx]) |=>
		unit_fault && !unit_grant)
		else $error("access to stopped unit not faulted");

	AST_GRANT_ON: assert property (
		@(posedge pclk) disable iff (!presetn)
		(unit_req && unit_clk_en_r[unit_req_idx]) |=>
		unit_grant && !unit_fault)
		else $error("access to running unit refused");

endmodule

`default_nettype wire

/* bench/rmcg_unit_model.sv */
`timescale 1ns/1ps
`default_nettype none

// far side: processor bus accesses aimed at units, and the unit clocks
module rmcg_unit_model (
	input wire logic pclk,
	input wire logic [7:0] unit_gclk,
	input wire logic unit_grant,
	input wire logic unit_fault,
	output logic unit_req,
	output logic [2:0] unit_req_idx
);
	// rising edges seen per unit clock; never cleared, the bench
	// takes differences so no second driver is needed
	int cnt [8] = '{default: 0};

	initial
	begin
		unit_req = 1'h0;
		unit_req_idx = 3'h0;
	end

	// a unit that is switched off must see no edge at all
	for (genvar g = 0; g < 8; g++)
	begin : g_cnt
		always @(posedge unit_gclk[g])
			cnt[g] <= cnt[g] + 1;
	end

	// one access, index held through the answer cycle, then scrambled
	// so that a stale index can not pass for a live one
	task automatic access(input logic [2:0] idx, output logic g,
		output logic f);
		@(posedge pclk);
		unit_req <= 1'h1;
		unit_req_idx <= idx;
		@(posedge pclk);
		unit_req <= 1'h0;
		// the answer stands for this one cycle; look in its middle
		@(negedge pclk);
		g = unit_grant;
		f = unit_fault;
		@(posedge pclk);
		unit_req_idx <= ~idx;
	endtask
endmodule

`default_nettype wire

/* bench/tb_top.sv */
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0;
	logic pwrite = 1'h0, auto_gate = 1'h0, slp = 1'h0, dslp = 1'h0;
	logic [11:0] paddr = 12'h0;
	logic [31:0] pwdata = 32'h0, sw = 32'h0, dw = 32'h0, prdata;
	logic pready, pslverr, ureq, ugrant, ufault, irq;
	logic [2:0] uidx;
	logic [7:0] uen, ugclk;
	int n_mismatch = 0;
	int compares = 0;
	// gate bit of each unit, in unit index order
	int pos [8] = '{0, 1, 4, 12, 14, 16, 17, 18};

	rmcg_top i_dut (.pclk(pclk), .presetn(presetn), .paddr(paddr),
		.psel(psel), .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr),
		.auto_clock_gating_select(auto_gate), .sleep_mode(slp),
		.deep_sleep_mode(dslp), .sleep_mode_unit_clock_gate_1(sw),
		.deep_sleep_unit_clock_gate_1(dw), .unit_req(ureq),
		.unit_req_idx(uidx), .unit_grant(ugrant), .unit_fault(ufault),
		.unit_clk_en(uen), .unit_gclk(ugclk), .irq(irq));

	rmcg_unit_model i_unit (.pclk(pclk), .unit_gclk(ugclk),
		.unit_grant(ugrant), .unit_fault(ufault), .unit_req(ureq),
		.unit_req_idx(uidx));

	// 250 MHz system clock
	initial
	begin
		forever #2 pclk = ~pclk;
	end

	task automatic chk(input logic [31:0] got, input logic [31:0] exp,
		input string msg);
		compares++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("[FAIL] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask

	// one apb transfer; waits for pready under a bounded count
	task automatic apb(input logic w, input logic [11:0] a,
		input logic [31:0] d, output logic [31:0] r, output logic e);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1'h1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge pclk);
		penable <= 1'h1;
		do
		begin
			@(posedge pclk);
			n++;
		end
		while (pready !== 1'h1 && n < 50);
		if (n >= 50)
		begin
			chk(32'h0, 32'h1, "pready never came");
			complete_run();
		end
		r = prdata;
		e = pslverr;
		psel <= 1'h0;
		penable <= 1'h0;
	endtask

	task automatic wr(input logic [11:0] a, input logic [31:0] d);
		logic [31:0] r;
		logic e;
		apb(1'h1, a, d, r, e);
	endtask

	task automatic rdchk(input logic [11:0] a, input logic [31:0] exp,
		input logic expe);
		logic [31:0] r;
		logic e;
		apb(1'h0, a, 32'h0, r, e);
		chk(r, exp, "read data");
		chk({31'h0, e}, {31'h0, expe}, "slave error");
	endtask

	// one unit access, judged against the expected answer
	task automatic acc(input logic [2:0] i, input logic f);
		logic g, ff;
		i_unit.access(i, g, ff);
		chk({30'h0, g, ff}, {30'h0, ~f, f}, "unit answer");
	endtask

	task automatic t_reset();
		rdchk(12'h104, 32'h0, 1'h0);
		chk({24'h0, uen}, 32'h0, "enables after reset");
		acc(3'h0, 1'h1);
	endtask

	// reserved bits, neighbours of the gate register unmapped
	task automatic t_fields();
		wr(12'h104, 32'hFFFF_FFFF);
		rdchk(12'h104, 32'h0007_5013, 1'h0);
		wr(12'h104, 32'hFFF8_AFEC);
		rdchk(12'h104, 32'h0, 1'h0);
		wr(12'h108, 32'hFFFF_FFFF);
		rdchk(12'h100, 32'h0, 1'h1);
		rdchk(12'h104, 32'h0, 1'h0);
	endtask

	// each unit alone: enable, clock activity and access answers
	task automatic t_units();
		int s [8];
		for (int i = 0; i < 8; i++)
		begin
			wr(12'h104, 32'h1 << pos[i]);
			repeat (2) @(posedge pclk);
			@(negedge pclk);
			chk({24'h0, uen}, 32'h1 << i, "unit enable");
			s = i_unit.cnt;
			repeat (10) @(negedge pclk);
			for (int j = 0; j < 8; j++)
				chk(i_unit.cnt[j] - s[j], (i == j) ? 10 : 0, "edges");
			acc(i[2:0], 1'h0);
			acc(i[2:0] + 3'h1, 1'h1);
		end
	endtask

	// faults land in a sticky status, masked onto the interrupt
	task automatic t_irq();
		// every unit faulted at least once above; the read empties the status
		rdchk(12'h180, 32'h0000_00FF, 1'h0);
		wr(12'h104, 32'h0);
		wr(12'h184, 32'h0000_00FF);
		acc(3'h2, 1'h1);
		@(posedge pclk);
		chk({31'h0, irq}, 32'h1, "irq raised");
		rdchk(12'h180, 32'h0000_0004, 1'h0);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0, "irq cleared");
		wr(12'h180, 32'hFFFF_FFFF);
		rdchk(12'h180, 32'h0, 1'h0);
		wr(12'h184, 32'h0);
		acc(3'h3, 1'h1);
		repeat (2) @(posedge pclk);
		chk({31'h0, irq}, 32'h0, "irq masked");
		rdchk(12'h180, 32'h0000_0008, 1'h0);
	endtask

	task automatic setm(input logic a, input logic s, input logic d,
		input logic [31:0] exp);
		@(posedge pclk);
		auto_gate <= a;
		slp <= s;
		dslp <= d;
		repeat (3) @(posedge pclk);
		chk({24'h0, uen}, exp, "mode enables");
	endtask

	// low-power words only govern under auto gating
	// software updates the gate word by read-modify-write
	task automatic t_modes();
		logic [31:0] r;
		logic e;
		apb(1'h0, 12'h104, 32'h0, r, e);
		chk(r, 32'h0, "rmw read");
		wr(12'h104, (r & 32'hFFF8_AFEC) | 32'h0000_0013);
		sw <= 32'h0007_0000;
		dw <= 32'h0000_5000;
		setm(1'h0, 1'h1, 1'h0, 32'h07);
		setm(1'h1, 1'h0, 1'h0, 32'h07);
		setm(1'h1, 1'h1, 1'h0, 32'hE0);
		setm(1'h1, 1'h1, 1'h1, 32'h18);
		setm(1'h0, 1'h0, 1'h0, 32'h07);
	endtask

	task automatic complete_run();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask

	// the whole run needs a few hundred cycles; cut a hang well after
	initial
	begin
		#100000;
		n_mismatch++;
		complete_run();
	end

	initial
	begin
		repeat (5) @(posedge pclk);
		presetn <= 1'h1;
		t_reset();
		t_fields();
		t_units();
		t_irq();
		t_modes();
		complete_run();
	end
endmodule

`default_nettype wire
